// ==== core/twsp_pkg.sv ====
// Types of the two-wire slave register port.
// Assumes the constants header is on the include path.
package twsp_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_MACK = 5'h10
    } twsp_state_e;

    typedef struct packed {
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_p;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_p;
        logic        sel_s1;
        logic        sel_s2;
        twsp_state_e st;
        logic [2:0]  cnt;
        logic [7:0]  sh;
        logic        first;
        logic        rw;
        logic        drv;
        logic        half;
        logic [1:0]  idx;
        logic [15:0] ptr;
        logic [7:0]  wd_hi;
        logic [15:0] word;
        logic        ovr_v;
        logic [6:0]  ovr;
        logic        oe_n;
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } twsp_regs_s;

endpackage : twsp_pkg

// ==== core/twsp_regs.svh ====
// Constants of the two-wire slave register port.
// Assumes inclusion by bare name from the core module and the bench.
`ifndef TWSP_REGS_SVH
`define TWSP_REGS_SVH

// Address bytes, write form (bit 0 clear)
`define TWSP_ADDR_DEFAULT 8'h90
`define TWSP_ADDR_ALT     8'hBA
// Register that overrides the slave address (low data byte, write form)
`define TWSP_ID_REG       16'hFC00
// Pointer step per 16-bit word
`define TWSP_ADDR_INC     16'h0002
// Bit counter
`define TWSP_BIT_FIRST    3'h0
`define TWSP_BIT_STEP     3'h1
`define TWSP_BIT_LAST     3'h7
// Message byte slots of a write
`define TWSP_IDX_PTR_HI   2'h0
`define TWSP_IDX_PTR_LO   2'h1
`define TWSP_IDX_DAT_HI   2'h2
`define TWSP_IDX_DAT_LO   2'h3
// Assertion bound on waiting for a serial clock edge
`define TWSP_EDGE_WAIT    100

`endif

// ==== core/twsp_slave.sv ====
// Two-wire slave port giving a bus master access to 16-bit registers.
// Assumes an open-drain data line resolved outside, and a register
// file on the system clock answering REG_RDATA_I while REG_RD_O is high.
`timescale 1ns/10ps
`include "twsp_regs.svh"

module twsp_slave #(
    parameter logic [15:0] ADDR_INC = `TWSP_ADDR_INC
) (
    // Clock, reset, enable
    input  wire logic        CLK_SYS_I,
    input  wire logic        NRST_I,
    input  wire logic        CE_I,
    // Two-wire bus pins
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE_N_O,
    // Address select strap
    input  wire logic        ADDR_SEL_I,
    // Register access port
    output logic [15:0]      REG_ADDR_O,
    output logic [15:0]      REG_WDATA_O,
    output logic             REG_WR_O,
    output logic             REG_RD_O,
    input  wire logic [15:0] REG_RDATA_I,
    // Status
    output logic             BUSY_O,
    output logic [6:0]       SLAVE_ADDR_O,
    output twsp_pkg::twsp_state_e STATE_O
);
    import twsp_pkg::*;

    if (ADDR_INC == 16'h0000) begin : g_chk
        $error("ADDR_INC must be nonzero");
    end

    twsp_regs_s q;
    twsp_regs_s d;

    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic [7:0] byte_in;
    logic [7:0] tx_byte;
    logic [6:0] cur_addr;
    logic       addr_match;
    logic       byte_done;

    // Edge and condition detection on synchronised lines
    assign scl_rise = q.scl_s2 & ~q.scl_p;
    assign scl_fall = ~q.scl_s2 & q.scl_p;
    assign start_c  = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
    assign stop_c   = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
    assign byte_in  = {q.sh[6:0], q.sda_s2};
    assign tx_byte  = q.half ? q.word[7:0] : q.word[15:8];
    assign byte_done = (q.st == ST_RX) & scl_rise & (q.cnt == `TWSP_BIT_LAST);

    // Current slave address: override, else strap
    always_comb begin
        if (q.ovr_v) begin
            cur_addr = q.ovr;
        end else if (q.sel_s2) begin
            cur_addr = 7'(`TWSP_ADDR_ALT >> 1);
        end else begin
            cur_addr = 7'(`TWSP_ADDR_DEFAULT >> 1);
        end
    end

    assign addr_match = (byte_in[7:1] == cur_addr);

    always_comb begin
        d        = q;
        d.wr     = 1'b0;
        d.rd     = 1'b0;
        d.scl_s1 = SCL_I;
        d.scl_s2 = q.scl_s1;
        d.scl_p  = q.scl_s2;
        d.sda_s1 = SDA_I;
        d.sda_s2 = q.sda_s1;
        d.sda_p  = q.sda_s2;
        d.sel_s1 = ADDR_SEL_I;
        d.sel_s2 = q.sel_s1;
        if (q.rd) begin
            d.word = REG_RDATA_I;
        end
        if (start_c) begin
            d.st    = ST_RX;
            d.cnt   = `TWSP_BIT_FIRST;
            d.first = 1'b1;
            d.drv   = 1'b0;
            d.oe_n  = 1'b1;
        end else if (stop_c) begin
            d.st   = ST_IDLE;
            d.oe_n = 1'b1;
        end else begin
            unique case (q.st)
                ST_IDLE: begin
                    d.oe_n = 1'b1;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        d.sh  = byte_in;
                        d.cnt = q.cnt + `TWSP_BIT_STEP;
                    end
                    if (byte_done) begin
                        d.st  = ST_ACK;
                        d.drv = 1'b0;
                        if (q.first) begin
                            d.first = 1'b0;
                            if (!addr_match) begin
                                d.st = ST_IDLE;
                            end else begin
                                d.rw   = byte_in[0];
                                d.idx  = `TWSP_IDX_PTR_HI;
                                d.half = 1'b0;
                                if (byte_in[0]) begin
                                    d.rd   = 1'b1;
                                    d.addr = q.ptr;
                                end
                            end
                        end else begin
                            unique case (q.idx)
                                `TWSP_IDX_PTR_HI: begin
                                    d.ptr[15:8] = byte_in;
                                    d.idx       = `TWSP_IDX_PTR_LO;
                                end
                                `TWSP_IDX_PTR_LO: begin
                                    d.ptr[7:0] = byte_in;
                                    d.idx      = `TWSP_IDX_DAT_HI;
                                end
                                `TWSP_IDX_DAT_HI: begin
                                    d.wd_hi = byte_in;
                                    d.idx   = `TWSP_IDX_DAT_LO;
                                end
                                `TWSP_IDX_DAT_LO: begin
                                    d.wr    = 1'b1;
                                    d.addr  = q.ptr;
                                    d.wdata = {q.wd_hi, byte_in};
                                    d.ptr   = q.ptr + ADDR_INC;
                                    d.idx   = `TWSP_IDX_DAT_HI;
                                    if (q.ptr == `TWSP_ID_REG) begin
                                        d.ovr_v = 1'b1;
                                        d.ovr   = byte_in[7:1];
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (!q.drv) begin
                            d.oe_n = 1'b0;
                            d.drv  = 1'b1;
                        end else begin
                            d.drv = 1'b0;
                            d.cnt = `TWSP_BIT_FIRST;
                            if (q.rw) begin
                                d.st   = ST_TX;
                                d.oe_n = tx_byte[`TWSP_BIT_LAST];
                            end else begin
                                d.st   = ST_RX;
                                d.oe_n = 1'b1;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        d.oe_n = tx_byte[`TWSP_BIT_LAST - q.cnt];
                    end
                    if (scl_rise) begin
                        d.cnt = q.cnt + `TWSP_BIT_STEP;
                        if (q.cnt == `TWSP_BIT_LAST) begin
                            d.st = ST_MACK;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_fall) begin
                        d.oe_n = 1'b1;
                    end
                    if (scl_rise) begin
                        d.half = ~q.half;
                        d.cnt  = `TWSP_BIT_FIRST;
                        if (q.half) begin
                            d.ptr = q.ptr + ADDR_INC;
                        end
                        if (q.sda_s2) begin
                            d.st = ST_IDLE;
                        end else begin
                            d.st = ST_TX;
                            if (q.half) begin
                                d.rd   = 1'b1;
                                d.addr = q.ptr + ADDR_INC;
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            q      <= '0;
            q.st   <= ST_IDLE;
            q.oe_n <= 1'b1;
        end else if (CE_I) begin
            q <= d;
        end
    end

    // Open drain: only the enable moves, and it drives low only after a clock fall
    assign SDA_O        = 1'b0;
    assign SDA_OE_N_O   = q.oe_n;
    assign REG_ADDR_O   = q.addr;
    assign REG_WDATA_O  = q.wdata;
    assign REG_WR_O     = q.wr;
    assign REG_RD_O     = q.rd;
    assign BUSY_O       = (q.st != ST_IDLE);
    assign SLAVE_ADDR_O = cur_addr;
    assign STATE_O      = q.st;

    // Checks
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!NRST_I || !CE_I);

    localparam int EDGE_WAIT = `TWSP_EDGE_WAIT;

    logic quiet;
    assign quiet = !start_c && !stop_c;

    a_idle_released: assert property (
        (q.st == ST_IDLE) |-> q.oe_n)
        else $error("line driven while idle");

    a_start_begins: assert property (
        start_c |=> (q.st == ST_RX) && q.first && (q.cnt == `TWSP_BIT_FIRST))
        else $error("start not taken");

    a_stop_ends: assert property (
        (stop_c && !start_c) |=> (q.st == ST_IDLE) ##1 q.oe_n)
        else $error("stop not taken");

    a_addr_nomatch: assert property (
        (byte_done && q.first && !addr_match && quiet)
        |=> (q.st == ST_IDLE) ##1 q.oe_n [*4])
        else $error("foreign address answered");

    a_addr_ack: assert property (
        (byte_done && q.first && addr_match && quiet)
        |=> (q.st == ST_ACK) ##[0:EDGE_WAIT] !q.oe_n)
        else $error("own address not acknowledged");

    a_read_fetch: assert property (
        (byte_done && q.first && addr_match && byte_in[0] && quiet)
        |=> q.rd && (q.addr == $past(q.ptr)))
        else $error("read fetch wrong");

    a_write_store: assert property (
        q.wr |-> (q.idx == `TWSP_IDX_DAT_HI) && (q.ptr == q.addr + ADDR_INC)
                 && (q.wdata[15:8] == q.wd_hi))
        else $error("write word wrong");

    a_ptr_msb_first: assert property (
        (byte_done && !q.first && (q.idx == `TWSP_IDX_PTR_HI) && quiet)
        |=> (q.ptr[15:8] == $past(byte_in)))
        else $error("pointer high byte misplaced");

    a_data_stable: assert property (
        (q.scl_s2 && q.scl_p && (q.st == ST_TX) && quiet) |=> $stable(q.oe_n))
        else $error("data moved while clock high");

    a_ack_release: assert property (
        ((q.st == ST_ACK) && q.drv && scl_fall && !q.rw && quiet)
        |=> q.oe_n && (q.st == ST_RX))
        else $error("acknowledge not released");

    a_nack_ends: assert property (
        ((q.st == ST_MACK) && scl_rise && q.sda_s2 && quiet)
        |=> (q.st == ST_IDLE) && q.oe_n)
        else $error("no-acknowledge did not end read");

    a_id_override: assert property (
        (q.wr && (q.addr == `TWSP_ID_REG)) |-> q.ovr_v && (cur_addr == q.wdata[7:1]))
        else $error("slave address not overridden");

    c_write_word: cover property (q.wr);
    c_read_word: cover property ((q.st == ST_MACK) && scl_rise && q.half);
    c_restart: cover property (start_c && (q.st != ST_IDLE));
    c_override: cover property (q.wr && (q.addr == `TWSP_ID_REG));

endmodule : twsp_slave

// ==== testbench/two_wire_slave_register_port_tb.sv ====
// Self-checking bench for the two-wire slave port.
// Assumes the host model drives the bus; register file answers address xor a key.
`timescale 1ns/10ps
`include "twsp_regs.svh"

module two_wire_slave_register_port_tb;
    import twsp_pkg::*;

    localparam logic [15:0] KEY = 16'hC35A;

    logic        clk;
    logic        nrst;
    logic        addr_sel;
    logic        scl;
    logic        sda_m;
    wire logic   sda_line;
    logic        sda_o;
    logic        sda_oe_n;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    twsp_state_e state;
    int          rd_cnt;
    int          n1;
    logic [15:0] reg_rdata;
    logic        busy;
    logic [6:0]  slave_addr;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic [15:0] w;
    int          wr_cnt;
    int          n0;
    int          n_mismatch;
    int          n_checks;

    assign sda_line  = sda_m & (sda_oe_n ? 1'b1 : sda_o);
    assign reg_rdata = reg_addr ^ KEY;

    twsp_slave twsp_slave_inst (
        .CLK_SYS_I(clk), .NRST_I(nrst), .CE_I(1'b1), .SCL_I(scl), .SDA_I(sda_line),
        .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n), .ADDR_SEL_I(addr_sel),
        .REG_ADDR_O(reg_addr), .REG_WDATA_O(reg_wdata), .REG_WR_O(reg_wr), .REG_RD_O(reg_rd),
        .REG_RDATA_I(reg_rdata), .BUSY_O(busy), .SLAVE_ADDR_O(slave_addr), .STATE_O(state)
    );

    twsp_host_model twsp_host_model_inst (
        .clk_i(clk), .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_m)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Register file write capture and read count
    always @(posedge clk) begin
        if (reg_rd === 1'b1) begin
            rd_cnt++;
        end
        if (reg_wr === 1'b1) begin
            wr_cnt++;
            wr_addr <= reg_addr;
            wr_data <= reg_wdata;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic put(input logic [7:0] b, input logic ack_exp, input string msg);
        logic a;
        twsp_host_model_inst.send_byte(b, a);
        check(16'(a), 16'(ack_exp), msg);
    endtask : put

    task automatic write_word(input logic [7:0] dev, input logic [15:0] ptr,
                              input logic [15:0] dat);
        twsp_host_model_inst.start();
        put(dev, 1'b1, "address ack");
        put(ptr[15:8], 1'b1, "pointer ack");
        put(ptr[7:0], 1'b1, "pointer ack");
        put(dat[15:8], 1'b1, "data ack");
        put(dat[7:0], 1'b1, "data ack");
        twsp_host_model_inst.stop();
        repeat (4) @(negedge clk);
    endtask : write_word

    task automatic read_word(input logic [7:0] devw, input logic [7:0] devr,
                             input logic [15:0] ptr, input logic with_ptr,
                             output logic [15:0] wd);
        logic [7:0] h;
        logic [7:0] l;
        if (with_ptr) begin
            twsp_host_model_inst.start();
            put(devw, 1'b1, "address ack");
            put(ptr[15:8], 1'b1, "pointer ack");
            put(ptr[7:0], 1'b1, "pointer ack");
        end
        twsp_host_model_inst.start();
        put(devr, 1'b1, "read address ack");
        twsp_host_model_inst.recv_byte(1'b1, h);
        twsp_host_model_inst.recv_byte(1'b0, l);
        twsp_host_model_inst.stop();
        wd = {h, l};
    endtask : read_word

    task automatic sc_write_default;
        n0 = wr_cnt;
        write_word(8'h90, 16'h1234, 16'hABCD);
        check(16'(wr_cnt - n0), 16'h0001, "write count");
        check(wr_addr, 16'h1234, "write address");
        check(wr_data, 16'hABCD, "write data");
        check(16'({scl, sda_line, busy}), 16'h0006, "idle after stop");
        check(16'(slave_addr), 16'h0048, "strap low address");
        check(16'(state), 16'h0001, "idle state after stop");
    endtask : sc_write_default

    task automatic sc_wrong_addr;
        n0 = wr_cnt;
        twsp_host_model_inst.start();
        put(8'hBA, 1'b0, "foreign address");
        put(8'h12, 1'b0, "passive after mismatch");
        twsp_host_model_inst.stop();
        check(16'(wr_cnt - n0), 16'h0000, "no write");
    endtask : sc_wrong_addr

    task automatic sc_reads;
        n1 = rd_cnt;
        read_word(8'h90, 8'h91, 16'h0040, 1'b1, w);
        check(w, 16'h0040 ^ KEY, "random read");
        twsp_host_model_inst.start();
        put(8'h90, 1'b1, "address ack");
        put(8'h01, 1'b1, "pointer ack");
        put(8'h00, 1'b1, "pointer ack");
        twsp_host_model_inst.stop();
        read_word(8'h90, 8'h91, 16'h0000, 1'b0, w);
        check(w, 16'h0100 ^ KEY, "current read");
        check(16'(rd_cnt - n1), 16'h0002, "one fetch per word read");
    endtask : sc_reads

    task automatic sc_seq_write;
        n0 = wr_cnt;
        twsp_host_model_inst.start();
        put(8'h90, 1'b1, "address ack");
        for (int i = 0; i < 6; i++) begin
            put(8'(48'h0010_1111_2222 >> (40 - 8 * i)), 1'b1, "byte ack");
        end
        twsp_host_model_inst.stop();
        repeat (4) @(negedge clk);
        check(16'(wr_cnt - n0), 16'h0002, "two writes");
        check(wr_addr, 16'h0010 + `TWSP_ADDR_INC, "second address");
        check(wr_data, 16'h2222, "second data");
    endtask : sc_seq_write

    task automatic sc_alt_strap;
        addr_sel = 1'b1;
        repeat (6) @(negedge clk);
        check(16'(slave_addr), 16'h005D, "strap high address");
        twsp_host_model_inst.start();
        put(8'h90, 1'b0, "default ignored");
        twsp_host_model_inst.stop();
        write_word(8'hBA, 16'h0200, 16'h5AA5);
        check(wr_data, 16'h5AA5, "alternate write");
        read_word(8'hBA, 8'hBB, 16'h0300, 1'b1, w);
        check(w, 16'h0300 ^ KEY, "alternate read");
        addr_sel = 1'b0;
        repeat (6) @(negedge clk);
    endtask : sc_alt_strap

    task automatic sc_override;
        write_word(8'h90, `TWSP_ID_REG, 16'h0050);
        check(16'(slave_addr), 16'h0028, "override address");
        twsp_host_model_inst.start();
        put(8'h90, 1'b0, "old address ignored");
        twsp_host_model_inst.stop();
        write_word(8'h50, 16'h0400, 16'h7777);
        check(wr_addr, 16'h0400, "override write");
    endtask : sc_override

    task report_and_stop;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        nrst     = 1'b0;
        addr_sel = 1'b0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (6) @(negedge clk);
        sc_write_default();
        sc_wrong_addr();
        sc_reads();
        sc_seq_write();
        sc_alt_strap();
        sc_override();
        report_and_stop();
    end

endmodule : two_wire_slave_register_port_tb

// ==== testbench/twsp_host_model.sv ====
// Bus master model for the two-wire slave port.
// Assumes a pulled-up data line resolved by the bench; paced by system clock negedges.
`timescale 1ns/10ps

module twsp_host_model (
    // Pacing clock
    input  wire logic clk_i,
    // Bus lines
    input  wire logic sda_line_i,
    output logic      scl_o,
    output logic      sda_o
);

    // Idle bus, clock stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic q_wait;
        repeat (2) @(negedge clk_i);
    endtask : q_wait

    // One clock period, data set while low, sampled mid high
    task automatic bit_clk(input logic d, output logic s);
        sda_o = d;
        q_wait();
        scl_o = 1'b1;
        q_wait();
        s = sda_line_i;
        q_wait();
        scl_o = 1'b0;
        q_wait();
    endtask : bit_clk

    // Start or repeated start
    task automatic start;
        sda_o = 1'b1;
        q_wait();
        scl_o = 1'b1;
        q_wait();
        sda_o = 1'b0;
        q_wait();
        scl_o = 1'b0;
        q_wait();
    endtask : start

    // Stop, leaves bus idle
    task automatic stop;
        sda_o = 1'b0;
        q_wait();
        scl_o = 1'b1;
        q_wait();
        sda_o = 1'b1;
        q_wait();
    endtask : stop

    // Byte out, then released line read as acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(b[i], s);
        end
        bit_clk(1'b1, s);
        ack = ~s;
    endtask : send_byte

    // Byte in, then acknowledge or no-acknowledge
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(1'b1, s);
            b[i] = s;
        end
        bit_clk(~ack, s);
    endtask : recv_byte

endmodule : twsp_host_model
